// ===== logic/irq_ctrl_pkg.sv
// constants and types shared by the interrupt front end
package irq_ctrl_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [1:0] ADDR_W = 2'h2;
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_PERIPH = 2'h1;
    localparam logic [1:0] ADDR_OPTION = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;
    // interrupt_control field positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_EN = 6;
    localparam int BIT_T0_EN = 5;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_PC_EN = 3;
    localparam int BIT_T0_FLAG = 2;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_PC_FLAG = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'h01;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    // ****************************************
    // timing: instruction cycle = 4 clocks (Q1..Q4)
    // ****************************************
    localparam int Q_PER_CYCLE = 4;
    localparam logic [1:0] LATENCY_TCY = 2'h3;
    typedef enum logic [1:0] {
        Q1 = 2'h0,
        Q2 = 2'h1,
        Q3 = 2'h3,
        Q4 = 2'h2
    } qphase_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_WAIT = 2'h1,
        ST_SLEEP = 2'h3,
        ST_WAKE = 2'h2
    } seq_state_t;
endpackage : irq_ctrl_pkg

// ===== logic/irq_src_if.sv
// source-side event interface between the front end and its edge detector
`timescale 1ns/100ps
interface irq_src_if;
    logic pin_level;
    logic edge_sel;
    logic edge_seen;
    modport detector (input pin_level, input edge_sel, output edge_seen);
    modport ctrl (output pin_level, output edge_sel, input edge_seen);
endinterface : irq_src_if

// ===== logic/ext_edge_detect.sv
// selectable-edge detector for the external interrupt pin
`timescale 1ns/100ps
module ext_edge_detect (
    input wire logic clk_i,
    input wire logic rst_n_i,
    irq_src_if.detector src
);
    typedef struct packed {
        logic prev;
        logic armed;
        logic seen;
    } state_t;
    state_t s_q;
    state_t s_d;
    always_comb begin
        s_d = s_q;
        s_d.prev = src.pin_level;
        // no edge until one real sample of the pin is held
        s_d.armed = 1'b1;
        s_d.seen = s_q.armed & (src.edge_sel ? (src.pin_level & ~s_q.prev)
                                             : (~src.pin_level & s_q.prev));
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign src.edge_seen = s_q.seen;
endmodule : ext_edge_detect

// ===== logic/core_interrupt_control.sv
// interrupt front end: flags, enables, vectoring and sleep wake-up
`timescale 1ns/100ps
// Functional notes
// - synchronous event starts vector code exactly three instruction cycles later.
// - asynchronous event starts vector code three or four cycles later.
// - latency is the same for one- and two-cycle instructions.
// - pin flag may set in Q4 or Q1; request sampled each Q1.
// - only clockless sources enabled before sleep wake the device; the code also wakes on an enabled timer0 flag.
// - after wake, vector if global enable set, else continue sequentially.
// - instruction after sleep always runs before vectoring.
// - pin edge selectable: 1 rising, 0 falling.
// - valid pin edge sets its flag; vectors when enabled globally.
// - pin enable clear blocks interrupt, flag still sets.
// - hardware saves only return address on the stack.
// - vector loads address 0004h; pc high latch untouched.
// - bit 7 global enable gates every interrupt.
// - bit 6 peripheral group enable gates peripheral requests.
// - bits 5,4,3 enable timer0, pin and port-change sources.
// - bit 2 timer0 overflow flag, sticky until software clear.
// - bit 1 pin flag, sticky until software clear.
// - bit 0 port-change flag, sticky; needs per-pin change enables.
// - flags set regardless of enable bits 7..3.
// - reset leaves timer0 alone, so its flag may reassert.
// - taking interrupt flushes prefetch, clears global enable, pushes pc.
// - return from interrupt pops pc and sets global enable.
// - reset clears global enable.
module core_interrupt_control #(
    parameter int PC_W = 13,
    parameter int PERIPH_N = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // sources
    input wire logic timer0_overflow_i,
    input wire logic ext_pin_i,
    input wire logic [7:0] port_change_i,
    input wire logic [7:0] port_change_pin_enable_i,
    input wire logic [PERIPH_N-1:0] periph_flags_i,
    input wire logic [PERIPH_N-1:0] periph_enables_i,
    // sequencer side
    input wire logic [PC_W-1:0] pc_i,
    input wire logic sleep_enter_i,
    input wire logic return_from_interrupt_i,
    input wire logic [PC_W-1:0] stack_top_i,
    output logic [1:0] q_phase_o,
    output logic irq_request_o,
    output logic flush_o,
    output logic push_o,
    output logic [PC_W-1:0] push_pc_o,
    output logic pop_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_load_value_o,
    output logic sleeping_o
);
    // ****************************************
    // parameter checks
    // ****************************************
    if (PC_W < 13 || PC_W > 16) begin : g_pc_chk
        $error("PC_W out of range");
    end
    if (PERIPH_N < 1 || PERIPH_N > 8) begin : g_per_chk
        $error("PERIPH_N out of range");
    end

    function automatic logic any_enabled(input logic [7:0] f, input logic [7:0] e);
        any_enabled = |(f & e);
    endfunction : any_enabled

    function automatic irq_ctrl_pkg::qphase_t next_q(input irq_ctrl_pkg::qphase_t q);
        case (q)
            irq_ctrl_pkg::Q1: next_q = irq_ctrl_pkg::Q2;
            irq_ctrl_pkg::Q2: next_q = irq_ctrl_pkg::Q3;
            irq_ctrl_pkg::Q3: next_q = irq_ctrl_pkg::Q4;
            default: next_q = irq_ctrl_pkg::Q1;
        endcase
    endfunction : next_q

    typedef struct packed {
        logic [7:0] control;
        logic edge_sel;
        logic [7:0] port_prev;
        logic sleep_global_en;
        logic sleeping;
        irq_ctrl_pkg::qphase_t q;
        irq_ctrl_pkg::seq_state_t st;
        logic [1:0] lat_cnt;
        logic pending;
        logic req;
        logic flush;
        logic push;
        logic [PC_W-1:0] push_pc;
        logic pop;
        logic pc_load;
        logic [PC_W-1:0] pc_val;
        logic [7:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    irq_src_if src ();
    logic pin_edge;
    logic port_evt;
    logic core_req;
    logic per_req;
    logic wake_src;
    logic [7:0] per_f;
    logic [7:0] per_e;

    assign src.pin_level = ext_pin_i;
    assign src.edge_sel = s_q.edge_sel;
    assign pin_edge = src.edge_seen;

    ext_edge_detect u_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src(src)
    );

    // ****************************************
    // request decode
    // ****************************************
    always_comb begin
        per_f = '0;
        per_e = '0;
        per_f[PERIPH_N-1:0] = periph_flags_i;
        per_e[PERIPH_N-1:0] = periph_enables_i;
        port_evt = |((port_change_i ^ s_q.port_prev) & port_change_pin_enable_i);
        core_req = any_enabled({5'h00, s_q.control[2:0]},
                               {5'h00, s_q.control[5:3]});
        per_req = s_q.control[irq_ctrl_pkg::BIT_PERIPH_EN] & any_enabled(per_f, per_e);
        wake_src = core_req | per_req;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.port_prev = port_change_i;
        s_d.flush = 1'b0;
        s_d.push = 1'b0;
        s_d.pop = 1'b0;
        s_d.pc_load = 1'b0;
        s_d.q = next_q(s_q.q);
        s_d.req = s_q.control[irq_ctrl_pkg::BIT_GLOBAL_EN] & (core_req | per_req);
        // register reads answer one cycle later
        if (reg_re_i) begin
            case (reg_addr_i)
                irq_ctrl_pkg::ADDR_CONTROL: s_d.rdata = s_q.control;
                irq_ctrl_pkg::ADDR_PERIPH: s_d.rdata = per_f;
                irq_ctrl_pkg::ADDR_OPTION: s_d.rdata = {7'h00, s_q.edge_sel};
                irq_ctrl_pkg::ADDR_STATUS: s_d.rdata = {4'h0, s_q.pending,
                                                        s_q.st == irq_ctrl_pkg::ST_SLEEP,
                                                        s_q.st};
                default: s_d.rdata = 8'h00;
            endcase
        end else begin
            s_d.rdata = 8'h00;
        end
        if (reg_we_i && reg_addr_i == irq_ctrl_pkg::ADDR_CONTROL) begin
            s_d.control = reg_wdata_i;
        end
        if (reg_we_i && reg_addr_i == irq_ctrl_pkg::ADDR_OPTION) begin
            s_d.edge_sel = reg_wdata_i[0];
        end
        // hardware sets win over a software clear in the same cycle
        if (timer0_overflow_i) begin
            s_d.control[irq_ctrl_pkg::BIT_T0_FLAG] = 1'b1;
        end
        if (pin_edge) begin
            s_d.control[irq_ctrl_pkg::BIT_EXT_FLAG] = 1'b1;
        end
        if (port_evt) begin
            s_d.control[irq_ctrl_pkg::BIT_PC_FLAG] = 1'b1;
        end
        if (return_from_interrupt_i) begin
            s_d.pop = 1'b1;
            s_d.pc_val = stack_top_i;
            s_d.control[irq_ctrl_pkg::BIT_GLOBAL_EN] = 1'b1;
        end
        case (s_q.st)
            irq_ctrl_pkg::ST_RUN: begin
                if (sleep_enter_i) begin
                    s_d.st = irq_ctrl_pkg::ST_SLEEP;
                end else if (s_q.q == irq_ctrl_pkg::Q1 && s_q.req) begin
                    // sampled once per cycle in Q1, independent of instruction length
                    s_d.st = irq_ctrl_pkg::ST_WAIT;
                    s_d.lat_cnt = 2'h1;
                    s_d.flush = 1'b1;
                    s_d.push = 1'b1;
                    s_d.push_pc = pc_i;
                    s_d.control[irq_ctrl_pkg::BIT_GLOBAL_EN] = 1'b0;
                end
            end
            irq_ctrl_pkg::ST_WAIT: begin
                if (s_q.q == irq_ctrl_pkg::Q4) begin
                    s_d.lat_cnt = s_q.lat_cnt + 2'h1;
                    if (s_q.lat_cnt == irq_ctrl_pkg::LATENCY_TCY - 2'h1) begin
                        s_d.st = irq_ctrl_pkg::ST_RUN;
                        s_d.pc_load = 1'b1;
                        s_d.pc_val = PC_W'(irq_ctrl_pkg::VECTOR_ADDR);
                    end
                end
            end
            irq_ctrl_pkg::ST_SLEEP: begin
                if (wake_src) begin
                    s_d.st = irq_ctrl_pkg::ST_WAKE;
                    s_d.sleep_global_en = s_q.control[irq_ctrl_pkg::BIT_GLOBAL_EN];
                end
            end
            irq_ctrl_pkg::ST_WAKE: begin
                // let the instruction after sleep run until the next Q4 first
                if (s_q.q == irq_ctrl_pkg::Q4) begin
                    s_d.st = irq_ctrl_pkg::ST_RUN;
                end
            end
            default: s_d.st = irq_ctrl_pkg::ST_RUN;
        endcase
        s_d.pending = s_q.req;
        s_d.sleeping = (s_d.st == irq_ctrl_pkg::ST_SLEEP);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.control <= irq_ctrl_pkg::CONTROL_RESET;
            s_q.edge_sel <= irq_ctrl_pkg::OPTION_RESET[0];
            s_q.q <= irq_ctrl_pkg::Q1;
            s_q.st <= irq_ctrl_pkg::ST_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign q_phase_o = s_q.q;
    assign irq_request_o = s_q.req;
    assign flush_o = s_q.flush;
    assign push_o = s_q.push;
    assign push_pc_o = s_q.push_pc;
    assign pop_o = s_q.pop;
    assign pc_load_o = s_q.pc_load;
    assign pc_load_value_o = s_q.pc_val;
    assign sleeping_o = s_q.sleeping;
endmodule : core_interrupt_control

// ===== dv/irq_ctrl_chk_asserts.sv
// assertions for the interrupt front end
`timescale 1ns/100ps
module irq_ctrl_chk #(
    parameter int PC_W = 13,
    parameter int PERIPH_N = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic return_from_interrupt_i,
    input wire logic [1:0] q_phase_o,
    input wire logic irq_request_o,
    input wire logic flush_o,
    input wire logic push_o,
    input wire logic pop_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_load_value_o,
    input wire logic sleeping_o
);
    // ****
    // checks
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    flush_push_a: assert property (flush_o |-> push_o)
        else $error("flush without push");
    push_cause_a: assert property (push_o |-> $past(irq_request_o))
        else $error("push without request");
    no_reentry_a: assert property (push_o |=> !push_o [*8])
        else $error("second push too soon");
    ret_pop_a: assert property (return_from_interrupt_i |=> pop_o)
        else $error("return without pop");
    vec_addr_a: assert property (pc_load_o |-> pc_load_value_o == PC_W'(13'h0004))
        else $error("vector address wrong");
    vec_lat_a: assert property (push_o |-> ##[1:16] pc_load_o)
        else $error("vector load late");
    rd_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read");
    phase_step_a: assert property (!sleeping_o && q_phase_o == 2'h0 |=> q_phase_o == 2'h1)
        else $error("phase order wrong");
    cover property (pc_load_o);
    cover property (pop_o);
    cover property ($fell(sleeping_o));
endmodule : irq_ctrl_chk

bind core_interrupt_control irq_ctrl_chk #(.PC_W(PC_W), .PERIPH_N(PERIPH_N)) chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .return_from_interrupt_i(return_from_interrupt_i), .q_phase_o(q_phase_o),
    .irq_request_o(irq_request_o), .flush_o(flush_o), .push_o(push_o), .pop_o(pop_o),
    .pc_load_o(pc_load_o), .pc_load_value_o(pc_load_value_o), .sleeping_o(sleeping_o));

// ===== dv/seq_model.sv
// sequencer partner: program counter and return stack
`timescale 1ns/100ps
module seq_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [12:0] push_pc_i,
    input wire logic pc_load_i,
    input wire logic [12:0] load_value_i,
    output logic [12:0] pc_o,
    output logic [12:0] stack_top_o
);
    logic [12:0] stack_q [8];
    logic [2:0] sp_q;
    assign stack_top_o = stack_q[sp_q-3'h1];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_o <= 13'h0000;
            sp_q <= 3'h0;
        end else begin
            if (push_i) begin
                stack_q[sp_q] <= push_pc_i;
                sp_q <= sp_q + 3'h1;
            end else if (pop_i) begin
                sp_q <= sp_q - 3'h1;
            end
            pc_o <= pc_load_i ? load_value_i : pc_o + 13'h0001;
        end
    end
endmodule : seq_model

// ===== dv/test_core_interrupt_control.sv
// self-checking bench for the interrupt front end
`timescale 1ns/100ps
module test_core_interrupt_control;
    logic clk_i, rst_n_i, we, re, t0, pin, slp, ret, req, flush, push, pop, load, sleeping;
    logic [1:0] addr, qph;
    logic [7:0] wd, rdata, chg, chg_en, pf, pe, v;
    logic [12:0] pc, top, ppc, lval;
    int mismatches, total_checks, n;
    int seed = 32'h454955f9;
    core_interrupt_control DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .timer0_overflow_i(t0), .ext_pin_i(pin), .port_change_i(chg),
        .port_change_pin_enable_i(chg_en), .periph_flags_i(pf), .periph_enables_i(pe),
        .pc_i(pc), .sleep_enter_i(slp), .return_from_interrupt_i(ret), .stack_top_i(top),
        .q_phase_o(qph), .irq_request_o(req), .flush_o(flush), .push_o(push),
        .push_pc_o(ppc), .pop_o(pop), .pc_load_o(load), .pc_load_value_o(lval),
        .sleeping_o(sleeping));
    seq_model partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .push_i(push), .pop_i(pop),
        .push_pc_i(ppc), .pc_load_i(load), .load_value_i(lval), .pc_o(pc), .stack_top_o(top));
    // ****
    // tasks
    // ****
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        addr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1 d = rdata;
        @(posedge clk_i);
    endtask : rd
    task automatic pulse_t0;
        t0 <= 1'b1;
        @(posedge clk_i);
        t0 <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : pulse_t0
    task automatic drive_pin(input logic l);
        pin <= l;
        repeat (12) @(posedge clk_i);
    endtask : drive_pin
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    // ****
    // stimulus
    // ****
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #800000;
        mismatches++;
        end_of_test();
    end
    initial begin
        {rst_n_i, we, re, t0, slp, ret, addr, wd, chg, chg_en, pf, pe} = '0;
        pin = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(2'h0, v);
        chk("control", 8'h00, v);
        rd(2'h2, v);
        chk("edge select", 8'h01, v & 8'h01);
        pulse_t0();
        rd(2'h0, v);
        chk("timer flag", 8'h04, v);
        repeat (20) @(posedge clk_i);
        rd(2'h0, v);
        chk("timer sticky", 8'h04, v);
        chk("request", 8'h00, {7'h00, req});
        wr(2'h0, 8'h00);
        $display("flag test done");
        drive_pin(1'b0);
        rd(2'h0, v);
        chk("wrong edge", 8'h00, v);
        wr(2'h2, 8'h00);
        drive_pin(1'b1);
        drive_pin(1'b0);
        rd(2'h0, v);
        chk("pin flag", 8'h02, v);
        $display("edge test done");
        wr(2'h0, 8'h90);
        pin <= 1'b1;
        repeat (12) @(posedge clk_i);
        pin <= 1'b0;
        n = 0;
        while (!load && n < 40) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk("latency", 8'h01, {7'h00, n >= 8 && n <= 24});
        chk("vector", 8'h04, lval[7:0]);
        @(posedge clk_i);
        rd(2'h0, v);
        chk("taken", 8'h12, v);
        wr(2'h0, 8'h10);
        ret <= 1'b1;
        @(posedge clk_i);
        ret <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(2'h0, v);
        chk("return", 8'h90, v);
        $display("vector test done");
        wr(2'h0, 8'h80);
        drive_pin(1'b1);
        drive_pin(1'b0);
        rd(2'h0, v);
        chk("masked pin", 8'h82, v);
        chk("masked request", 8'h00, {7'h00, req});
        wr(2'h0, 8'h00);
        chg <= 8'h5a;
        repeat (8) @(posedge clk_i);
        chg_en <= 8'hff;
        chg <= 8'ha5;
        repeat (8) @(posedge clk_i);
        rd(2'h0, v);
        chk("port change", 8'h01, v);
        chg_en <= 8'h00;
        wr(2'h0, 8'h00);
        $display("mask test done");
        repeat (20) begin
            v = $random(seed);
            pf <= $random(seed);
            pe <= $random(seed);
            wr(2'h0, v & 8'h78);
            rd(2'h0, wd);
            chk("enables", v & 8'h78, wd);
            chk("gated request", 8'h00, {7'h00, req});
        end
        {pf, pe} <= '0;
        wr(2'h0, 8'h20);
        slp <= 1'b1;
        @(posedge clk_i);
        slp <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("asleep", 8'h01, {7'h00, sleeping});
        pulse_t0();
        repeat (12) @(posedge clk_i);
        chk("woken", 8'h00, {7'h00, sleeping});
        rd(2'h0, v);
        chk("no vector", 8'h24, v);
        $display("sleep test done");
        end_of_test();
    end
endmodule : test_core_interrupt_control
